// File: core/uis_pkg.sv
package uis_pkg;

   // ----------------------------------------
   // register indices in the special-function space
   // ----------------------------------------
   localparam logic [3:0] REG_EVENT_FLAGS = 4'h0;
   localparam logic [3:0] REG_EVENT_ENABLES = 4'h1;
   localparam logic [3:0] REG_ERROR_FLAGS = 4'h2;
   localparam logic [3:0] REG_ERROR_ENABLES = 4'h3;
   localparam logic [3:0] REG_XFER_STATUS = 4'h4;
   localparam logic [3:0] REG_DEV_ADDR = 4'h5;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_FRAME_START = 6;
   localparam int BIT_STALL_SENT = 5;
   localparam int BIT_BUS_IDLE = 4;
   localparam int BIT_TRANSACTION_DONE = 3;
   localparam int BIT_BUS_ACTIVITY = 2;
   localparam int BIT_ERROR_SUMMARY = 1;
   localparam int BIT_BUS_RESET = 0;
   localparam int BIT_STUFFING_ERROR = 7;
   localparam int BIT_TURNAROUND_TIMEOUT = 4;
   localparam int BIT_PARTIAL_BYTE_ERROR = 3;
   localparam int BIT_DATA_CHECK_ERROR = 2;
   localparam int BIT_TOKEN_CHECK_ERROR = 1;
   localparam int BIT_PACKET_ID_ERROR = 0;

   // ----------------------------------------
   // masks and values after reset
   // ----------------------------------------
   localparam logic [7:0] EVENT_MASK = 8'h7F;
   localparam logic [7:0] EVENT_CLEARABLE = 8'h7D;
   localparam logic [7:0] ERROR_MASK = 8'h9F;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam logic [6:0] DEV_ADDR_RESET = 7'h00;
   localparam logic [1:0] LINE_IDLE = 2'h2;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam longint CLOCK_HZ = 10_000_000;
   localparam longint IDLE_TIME_US = 3000;
   localparam int IDLE_CYCLES = int'((IDLE_TIME_US * CLOCK_HZ + 999_999) / 1_000_000);
   localparam int IDLE_COUNT_W = 16;
   localparam logic [4:0] TURN_BIT_TIMES = 5'h10;
   localparam int XFER_FIFO_DEPTH = 4;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] endpoint;
      logic dir_in;
      logic odd_bank;
   } uis_xfer_t;

   typedef struct packed {
      logic frame_start;
      logic stall_sent;
      logic trn_done;
      logic trn_token;
      logic usb_reset;
      logic eop;
      logic response;
      logic bit_tick;
      uis_xfer_t xfer;
   } uis_eng_ev_t;

   typedef struct packed {
      logic stuffing;
      logic partial_byte;
      logic data_check;
      logic token_check;
      logic packet_id;
   } uis_err_ev_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } uis_sfr_req_t;

   typedef enum logic [0:0] {
      TURN_IDLE = 1'b0,
      TURN_WAIT = 1'b1
   } uis_turn_t;

endpackage : uis_pkg

// File: core/uis_xfer_fifo.sv
`timescale 1ns/100ps
module uis_xfer_fifo (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // write side
   input wire logic push,
   input uis_pkg::uis_xfer_t push_data,
   // read side
   input wire logic pop,
   output uis_pkg::uis_xfer_t head,
   output logic empty,
   output logic full
);
   import uis_pkg::*;

   typedef struct packed {
      uis_xfer_t [XFER_FIFO_DEPTH-1:0] mem;
      logic [1:0] wr_ptr;
      logic [1:0] rd_ptr;
      logic [2:0] count;
   } uis_fifo_state_t;

   uis_fifo_state_t s;
   uis_fifo_state_t next_s;
   logic do_push;
   logic do_pop;

   // a full fifo drops the entry unless one is popped in the same cycle; the engine is expected to refuse tokens then
   always_comb begin
      next_s = s;
      do_pop = pop && (s.count != 3'h0);
      do_push = push && ((s.count != 3'h4) || do_pop);
      if (do_push) begin
         next_s.mem[s.wr_ptr] = push_data;
         next_s.wr_ptr = s.wr_ptr + 2'h1;
      end
      if (do_pop) begin
         next_s.rd_ptr = s.rd_ptr + 2'h1;
      end
      next_s.count = s.count + {2'h0, do_push} - {2'h0, do_pop};
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign head = s.mem[s.rd_ptr];
   assign empty = (s.count == 3'h0);
   assign full = (s.count == 3'h4);

endmodule : uis_xfer_fifo

// File: core/uis_status.sv
`timescale 1ns/100ps
// Operation
// - frame-start token received sets event flag bit 6
// - stall handshake sent sets event flag bit 5
// - bus idle continuously for 3 ms sets event flag bit 4
// - finished transaction sets event flag bit 3; endpoint details readable
// - clearing transaction flag advances transfer-status fifo (IN, OUT, SETUP entries)
// - activity on the data lines sets event flag bit 2
// - summary bit 1 follows enabled error flags only; software cannot write it
// - valid bus reset sets event flag bit 0 and zeroes device address
// - event enables bits 6..0 reset to zero; bit 7 reads zero
// - bit-stuffing violation sets error flag bit 7
// - more than 16 idle bit times after end-of-packet sets error bit 4
// - data field not whole bytes sets error flag bit 3
// - failed 16-bit data check sets error flag bit 2
// - bad 5-bit token check rejects token, sets error flag bit 1
// - packet identifier check failure sets error flag bit 0
// - error enables bits 7, 4..0 reset zero; bits 6..5 read zero
// - unimplemented flag bits read zero; all flags reset to zero
// - transfer status shows endpoint number, direction and ping-pong bank
module uis_status #(
   parameter int unsigned IDLE_LIMIT = uis_pkg::IDLE_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // special-function register access
   input uis_pkg::uis_sfr_req_t sfr,
   output logic [7:0] sfr_rdata,
   // serial engine events
   input uis_pkg::uis_eng_ev_t eng_ev,
   input uis_pkg::uis_err_ev_t err_ev,
   // data line pins
   input wire logic line_dp,
   input wire logic line_dm,
   // to the core
   output logic module_interrupt_flag,
   output logic [6:0] device_address_register
);
   import uis_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] dp_sync;
      logic [2:0] dm_sync;
      logic [1:0] line;
      logic [7:0] ev_flags;
      logic [7:0] ev_en;
      logic [7:0] err_flags;
      logic [7:0] err_en;
      logic [6:0] dev_addr;
      logic [IDLE_COUNT_W-1:0] idle_count;
      uis_turn_t turn;
      logic [4:0] turn_bits;
      logic [7:0] rdata;
      logic irq;
   } uis_state_t;

   uis_state_t s;
   uis_state_t next_s;
   logic [1:0] agreed_line;
   logic line_agree;
   logic activity;
   logic idle_hit;
   logic turn_timeout;
   logic trn_set;
   logic fifo_pop;
   logic fifo_empty;
   logic wr_event_flags;
   logic [7:0] ev_set;
   logic [7:0] err_set;
   uis_xfer_t fifo_head;

   // ----------------------------------------
   // flag update: zero clears, one keeps, set wins
   // ----------------------------------------
   function automatic logic [7:0] uis_flag_update(
      input logic [7:0] flags,
      input logic wr,
      input logic [7:0] wdata,
      input logic [7:0] clearable,
      input logic [7:0] set
   );
      logic [7:0] keep;
      keep = wr ? (wdata | ~clearable) : 8'hFF;
      return (flags & keep) | set;
   endfunction : uis_flag_update

   // ----------------------------------------
   // transfer status fifo
   // ----------------------------------------
   uis_xfer_fifo u_xfer_fifo (
      .clock(clock),
      .resetn(resetn),
      .push(eng_ev.trn_done && eng_ev.trn_token),
      .push_data(eng_ev.xfer),
      .pop(fifo_pop),
      .head(fifo_head),
      .empty(fifo_empty),
      .full()
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_s = s;
      // only second and third stages are compared; the first may be metastable
      next_s.dp_sync = {s.dp_sync[1:0], line_dp};
      next_s.dm_sync = {s.dm_sync[1:0], line_dm};
      line_agree = (s.dp_sync[2] == s.dp_sync[1]) && (s.dm_sync[2] == s.dm_sync[1]);
      agreed_line = {s.dp_sync[1], s.dm_sync[1]};
      activity = line_agree && (agreed_line != s.line);
      if (line_agree) begin
         next_s.line = agreed_line;
      end

      // idle timer saturates so the flag is raised once per idle stretch
      idle_hit = 1'b0;
      if (s.line != LINE_IDLE || activity) begin
         next_s.idle_count = '0;
      end else if (s.idle_count != IDLE_COUNT_W'(IDLE_LIMIT)) begin
         next_s.idle_count = s.idle_count + 1'b1;
         idle_hit = (s.idle_count == IDLE_COUNT_W'(IDLE_LIMIT - 1));
      end

      // turnaround watch after each end-of-packet
      turn_timeout = 1'b0;
      case (s.turn)
         TURN_IDLE: begin
            if (eng_ev.eop) begin
               next_s.turn = TURN_WAIT;
               next_s.turn_bits = 5'h00;
            end
         end
         TURN_WAIT: begin
            if (eng_ev.response || s.line != LINE_IDLE) begin
               next_s.turn = TURN_IDLE;
            end else if (eng_ev.bit_tick) begin
               if (s.turn_bits == TURN_BIT_TIMES) begin
                  turn_timeout = 1'b1;
                  next_s.turn = TURN_IDLE;
               end else begin
                  next_s.turn_bits = s.turn_bits + 5'h01;
               end
            end
         end
         default: begin
            next_s.turn = TURN_IDLE;
         end
      endcase

      // register writes
      wr_event_flags = sfr.wr && (sfr.addr == REG_EVENT_FLAGS);
      fifo_pop = wr_event_flags && !sfr.wdata[BIT_TRANSACTION_DONE]
         && s.ev_flags[BIT_TRANSACTION_DONE] && !fifo_empty;
      // a queued entry re-raises the flag one cycle after the clear
      trn_set = eng_ev.trn_done || (!fifo_empty && !s.ev_flags[BIT_TRANSACTION_DONE]);

      ev_set = 8'h00;
      ev_set[BIT_FRAME_START] = eng_ev.frame_start;
      ev_set[BIT_STALL_SENT] = eng_ev.stall_sent;
      ev_set[BIT_BUS_IDLE] = idle_hit;
      ev_set[BIT_TRANSACTION_DONE] = trn_set;
      ev_set[BIT_BUS_ACTIVITY] = activity;
      ev_set[BIT_BUS_RESET] = eng_ev.usb_reset;

      err_set = 8'h00;
      err_set[BIT_STUFFING_ERROR] = err_ev.stuffing;
      err_set[BIT_TURNAROUND_TIMEOUT] = turn_timeout;
      err_set[BIT_PARTIAL_BYTE_ERROR] = err_ev.partial_byte;
      err_set[BIT_DATA_CHECK_ERROR] = err_ev.data_check;
      err_set[BIT_TOKEN_CHECK_ERROR] = err_ev.token_check;
      err_set[BIT_PACKET_ID_ERROR] = err_ev.packet_id;

      next_s.ev_flags = uis_flag_update(s.ev_flags, wr_event_flags, sfr.wdata,
         EVENT_CLEARABLE, ev_set) & EVENT_MASK;
      next_s.err_flags = uis_flag_update(s.err_flags, sfr.wr && (sfr.addr == REG_ERROR_FLAGS),
         sfr.wdata, ERROR_MASK, err_set) & ERROR_MASK;
      if (sfr.wr && sfr.addr == REG_EVENT_ENABLES) begin
         next_s.ev_en = sfr.wdata & EVENT_MASK;
      end
      if (sfr.wr && sfr.addr == REG_ERROR_ENABLES) begin
         next_s.err_en = sfr.wdata & ERROR_MASK;
      end
      next_s.ev_flags[BIT_ERROR_SUMMARY] = |(next_s.err_flags & next_s.err_en);

      if (eng_ev.usb_reset) begin
         next_s.dev_addr = DEV_ADDR_RESET;
      end else if (sfr.wr && sfr.addr == REG_DEV_ADDR) begin
         next_s.dev_addr = sfr.wdata[6:0];
      end

      // read data is captured one cycle after the strobe
      if (sfr.rd) begin
         case (sfr.addr)
            REG_EVENT_FLAGS: next_s.rdata = s.ev_flags;
            REG_EVENT_ENABLES: next_s.rdata = s.ev_en;
            REG_ERROR_FLAGS: next_s.rdata = s.err_flags;
            REG_ERROR_ENABLES: next_s.rdata = s.err_en;
            REG_XFER_STATUS: next_s.rdata = {1'b0, fifo_head.endpoint, fifo_head.dir_in,
               fifo_head.odd_bank, 1'b0};
            REG_DEV_ADDR: next_s.rdata = {1'b0, s.dev_addr};
            default: next_s.rdata = 8'h00;
         endcase
      end

      next_s.irq = |(next_s.ev_flags & next_s.ev_en);
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sfr_rdata = s.rdata;
   assign module_interrupt_flag = s.irq;
   assign device_address_register = s.dev_addr;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   sequence s_eop_then_quiet;
      eng_ev.eop && s.turn == TURN_IDLE ##1 (!eng_ev.response && s.line == LINE_IDLE)[*2];
   endsequence

   property p_frame_start;
      eng_ev.frame_start |=> s.ev_flags[BIT_FRAME_START];
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame start flag not set");

   property p_stall_sent;
      eng_ev.stall_sent |=> s.ev_flags[BIT_STALL_SENT];
   endproperty
   a_stall_sent: assert property (p_stall_sent) else $error("stall flag not set");

   property p_bus_idle;
      s.line == LINE_IDLE && !activity && s.idle_count == IDLE_COUNT_W'(IDLE_LIMIT - 1)
         |=> s.ev_flags[BIT_BUS_IDLE];
   endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("idle flag not set at limit");

   property p_idle_early;
      $rose(s.ev_flags[BIT_BUS_IDLE]) |-> s.idle_count == IDLE_COUNT_W'(IDLE_LIMIT);
   endproperty
   a_idle_early: assert property (p_idle_early) else $error("idle flag before limit");

   property p_trn_done;
      eng_ev.trn_done |=> s.ev_flags[BIT_TRANSACTION_DONE];
   endproperty
   a_trn_done: assert property (p_trn_done) else $error("transaction flag not set");

   property p_fifo_advance;
      fifo_pop && !(eng_ev.trn_done && eng_ev.trn_token) |=> $changed(u_xfer_fifo.s.rd_ptr);
   endproperty
   a_fifo_advance: assert property (p_fifo_advance) else $error("fifo did not advance");

   property p_activity;
      activity |=> s.ev_flags[BIT_BUS_ACTIVITY];
   endproperty
   a_activity: assert property (p_activity) else $error("activity flag not set");

   property p_summary;
      s.ev_flags[BIT_ERROR_SUMMARY] == |(s.err_flags & s.err_en);
   endproperty
   a_summary: assert property (p_summary) else $error("summary flag mismatch");

   property p_bus_reset;
      eng_ev.usb_reset |=> s.ev_flags[BIT_BUS_RESET] && device_address_register == DEV_ADDR_RESET;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset not handled");

   property p_reserved;
      s.ev_en[7] == 1'b0 && s.err_en[6:5] == 2'h0 && s.ev_flags[7] == 1'b0 && s.err_flags[6:5] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_errors;
      err_ev.stuffing |=> s.err_flags[BIT_STUFFING_ERROR];
   endproperty
   a_errors: assert property (p_errors) else $error("stuffing flag not set");

   // the tick count lives in turn_bits, so the long wait is checked through it, not by repetition
   property p_turn_armed;
      s_eop_then_quiet |-> s.turn == TURN_WAIT && s.turn_bits <= 5'h01;
   endproperty
   a_turn_armed: assert property (p_turn_armed) else $error("turnaround watch not armed");

   property p_turnaround;
      s.turn == TURN_WAIT && s.turn_bits == TURN_BIT_TIMES && eng_ev.bit_tick && !eng_ev.response
         && s.line == LINE_IDLE |=> s.err_flags[BIT_TURNAROUND_TIMEOUT];
   endproperty
   a_turnaround: assert property (p_turnaround) else $error("turnaround timeout missed");

   property p_turn_count;
      $rose(s.err_flags[BIT_TURNAROUND_TIMEOUT]) |-> $past(s.turn_bits) == TURN_BIT_TIMES;
   endproperty
   a_turn_count: assert property (p_turn_count) else $error("turnaround timeout too early");

   property p_partial;
      err_ev.partial_byte |=> s.err_flags[BIT_PARTIAL_BYTE_ERROR];
   endproperty
   a_partial: assert property (p_partial) else $error("partial byte flag not set");

   property p_data_check;
      err_ev.data_check |=> s.err_flags[BIT_DATA_CHECK_ERROR];
   endproperty
   a_data_check: assert property (p_data_check) else $error("data check flag not set");

   property p_token_check;
      err_ev.token_check |=> s.err_flags[BIT_TOKEN_CHECK_ERROR];
   endproperty
   a_token_check: assert property (p_token_check) else $error("token check flag not set");

   property p_packet_id;
      err_ev.packet_id |=> s.err_flags[BIT_PACKET_ID_ERROR];
   endproperty
   a_packet_id: assert property (p_packet_id) else $error("packet id flag not set");

   property p_xfer_read;
      sfr.rd && sfr.addr == REG_XFER_STATUS |=> sfr_rdata[6:1] == $past(fifo_head) && sfr_rdata[0] == 1'b0;
   endproperty
   a_xfer_read: assert property (p_xfer_read) else $error("transfer status read wrong");

   property p_irq;
      module_interrupt_flag == |(s.ev_flags & s.ev_en);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request mismatch");

   property p_set_wins;
      wr_event_flags && !sfr.wdata[BIT_FRAME_START] && eng_ev.frame_start |=> s.ev_flags[BIT_FRAME_START];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat hardware set");

   property p_write_one_keeps;
      wr_event_flags && sfr.wdata[BIT_STALL_SENT] && s.ev_flags[BIT_STALL_SENT] |=> s.ev_flags[BIT_STALL_SENT];
   endproperty
   a_write_one_keeps: assert property (p_write_one_keeps) else $error("write of one cleared flag");

endmodule : uis_status

// File: verification/uis_host_model.sv
`timescale 1ns/100ps
module uis_host_model (
   // clock
   input wire logic clock,
   // towards the device
   output uis_pkg::uis_eng_ev_t eng_ev,
   output uis_pkg::uis_err_ev_t err_ev,
   output logic line_dp,
   output logic line_dm
);
   import uis_pkg::*;

   // ----
   // bus starts in single-ended zero, as before attach
   // ----
   initial begin
      eng_ev = '0;
      err_ev = '0;
      line_dp = 1'h0;
      line_dm = 1'h0;
   end

   // ----
   // one event pulse, then a quiet cycle so callers never re-drive in one step
   // ----
   task automatic ev(input uis_eng_ev_t e, input uis_err_ev_t r);
      eng_ev = e;
      err_ev = r;
      @(posedge clock);
      #2;
      eng_ev = '0;
      err_ev = '0;
      @(posedge clock);
      #2;
   endtask : ev

   // ----
   // line levels, held until changed
   // ----
   task automatic line(input logic dp, input logic dm);
      line_dp = dp;
      line_dm = dm;
   endtask : line

endmodule : uis_host_model

// File: verification/usb_interrupt_status_logic_test.sv
`timescale 1ns/100ps
module usb_interrupt_status_logic_test;
   import uis_pkg::*;

   // ----
   // wiring
   // ----
   localparam int IDLE_SIM = 20;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] exp;
   } uis_note_t;
   logic clock = 1'h0;
   logic resetn = 1'h0;
   uis_sfr_req_t sfr = '0;
   logic [7:0] sfr_rdata;
   uis_eng_ev_t eng_ev;
   uis_err_ev_t err_ev;
   logic line_dp;
   logic line_dm;
   logic module_interrupt_flag;
   logic [6:0] device_address_register;
   uis_note_t notes[$];
   int miscompares = 0;
   int tests_run = 0;
   logic [7:0] rnd;
   logic [7:0] erren;
   uis_xfer_t x1;
   uis_xfer_t x2;
   uis_eng_ev_t e;

   always #50 clock = ~clock;

   uis_status #(.IDLE_LIMIT(IDLE_SIM)) uis_status_i (.clock(clock), .resetn(resetn), .sfr(sfr),
      .sfr_rdata(sfr_rdata), .eng_ev(eng_ev), .err_ev(err_ev), .line_dp(line_dp), .line_dm(line_dm),
      .module_interrupt_flag(module_interrupt_flag), .device_address_register(device_address_register));
   uis_host_model uis_host_model_i (.clock(clock), .eng_ev(eng_ev), .err_ev(err_ev), .line_dp(line_dp),
      .line_dm(line_dm));

   // ----
   // checking and bus tasks
   // ----
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : step

   // idle cycle after each access keeps strobes from being re-driven in one step
   task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      sfr = '{wr: w, rd: r, addr: a, wdata: d};
      step(1);
      sfr = '0;
      step(1);
   endtask : acc

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      acc(1'h1, 1'h0, a, d);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      notes.push_back('{addr: a, exp: exp});
      acc(1'h0, 1'h1, a, 8'h00);
   endtask : rd

   task automatic irq(input logic exp);
      check("interrupt", {7'h00, module_interrupt_flag}, {7'h00, exp});
   endtask : irq

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   // ----
   // read monitor: oldest note against each returned byte
   // ----
   always @(posedge clock) begin : watch
      uis_note_t n;
      if (sfr.rd === 1'h1) begin
         #1;
         if (notes.size() == 0) begin
            check("unexpected read", 8'h00, 8'hFF);
         end else begin
            n = notes.pop_front();
            check($sformatf("register %h", n.addr), sfr_rdata, n.exp);
         end
      end
   end

   initial begin
      repeat (4000) @(posedge clock);
      miscompares++;
      stop_test();
   end

   // ----
   // main sequence
   // ----
   initial begin
      void'($urandom(39));
      repeat (12) @(posedge clock);
      #2;
      resetn = 1'h1;
      step(1);
      irq(1'h0);
      for (int a = 0; a < 7; a++) begin
         rd(4'(a), 8'h00);
      end
      // ones written to status places never set anything
      for (int a = 0; a < 8; a += 2) begin
         wr(4'(a), 8'hFF);
         rd(4'(a), 8'h00);
      end
      rnd = 8'($urandom());
      wr(REG_EVENT_ENABLES, rnd);
      rd(REG_EVENT_ENABLES, rnd & EVENT_MASK);
      rnd = 8'($urandom());
      wr(REG_ERROR_ENABLES, rnd);
      rd(REG_ERROR_ENABLES, rnd & ERROR_MASK);
      // one error enabled, one masked for sure, the rest random
      erren = (8'($urandom()) & 8'h9A) | 8'h01;
      wr(REG_ERROR_ENABLES, erren);
      wr(REG_EVENT_ENABLES, 8'h7B);
      rnd = {1'h0, 7'($urandom())};
      wr(REG_DEV_ADDR, rnd);
      rd(REG_DEV_ADDR, rnd);
      for (int i = 0; i < 3; i++) begin
         e = '0;
         e.frame_start = (i == 0);
         e.stall_sent = (i == 1);
         e.usb_reset = (i == 2);
         rnd = (i == 0) ? 8'h40 : (i == 1) ? 8'h20 : 8'h01;
         uis_host_model_i.ev(e, '0);
         rd(REG_EVENT_FLAGS, rnd);
         irq(1'h1);
         wr(REG_EVENT_FLAGS, ~rnd);
         rd(REG_EVENT_FLAGS, 8'h00);
         irq(1'h0);
      end
      check("address", {1'h0, device_address_register}, 8'h00);
      rd(REG_DEV_ADDR, 8'h00);
      e = '0;
      e.frame_start = 1'h1;
      fork
         uis_host_model_i.ev(e, '0);
         wr(REG_EVENT_FLAGS, 8'hBF);
      join
      rd(REG_EVENT_FLAGS, 8'h40);
      wr(REG_EVENT_FLAGS, 8'h00);
      for (int i = 0; i < 5; i++) begin
         rnd = 8'h01 << ((i == 0) ? 7 : 4 - i);
         uis_host_model_i.ev('0, uis_err_ev_t'(5'h10 >> i));
         rd(REG_ERROR_FLAGS, rnd);
         rd(REG_EVENT_FLAGS, ((erren & rnd) != 8'h00) ? 8'h02 : 8'h00);
         irq((erren & rnd) != 8'h00);
         // a zero written to the summary place must not clear it
         wr(REG_EVENT_FLAGS, 8'h00);
         rd(REG_EVENT_FLAGS, ((erren & rnd) != 8'h00) ? 8'h02 : 8'h00);
         wr(REG_ERROR_FLAGS, ~rnd);
         rd(REG_EVENT_FLAGS, 8'h00);
      end
      x1 = uis_xfer_t'(6'($urandom()));
      x2 = uis_xfer_t'(6'($urandom()));
      e = '0;
      e.trn_done = 1'h1;
      e.trn_token = 1'h1;
      e.xfer = x1;
      uis_host_model_i.ev(e, '0);
      e.xfer = x2;
      uis_host_model_i.ev(e, '0);
      rd(REG_EVENT_FLAGS, 8'h08);
      rd(REG_XFER_STATUS, {1'h0, x1, 1'h0});
      wr(REG_EVENT_FLAGS, 8'hF7);
      rd(REG_EVENT_FLAGS, 8'h08);
      rd(REG_XFER_STATUS, {1'h0, x2, 1'h0});
      wr(REG_EVENT_FLAGS, 8'hF7);
      rd(REG_EVENT_FLAGS, 8'h00);
      // a finish without a token queues nothing, so no re-raise after the clear
      e.trn_token = 1'h0;
      uis_host_model_i.ev(e, '0);
      rd(REG_EVENT_FLAGS, 8'h08);
      wr(REG_EVENT_FLAGS, 8'hF7);
      rd(REG_EVENT_FLAGS, 8'h00);
      // bus leaves single-ended zero and settles at idle
      uis_host_model_i.line(1'h1, 1'h0);
      step(8);
      rd(REG_EVENT_FLAGS, 8'h04);
      irq(1'h0);
      step(IDLE_SIM);
      rd(REG_EVENT_FLAGS, 8'h14);
      irq(1'h1);
      wr(REG_EVENT_ENABLES, 8'h7F);
      wr(REG_EVENT_FLAGS, 8'h00);
      rd(REG_EVENT_FLAGS, 8'h00);
      // a response cancels the turnaround watch
      e = '0;
      e.eop = 1'h1;
      uis_host_model_i.ev(e, '0);
      e = '0;
      e.response = 1'h1;
      uis_host_model_i.ev(e, '0);
      e = '0;
      e.bit_tick = 1'h1;
      repeat (17) uis_host_model_i.ev(e, '0);
      rd(REG_ERROR_FLAGS, 8'h00);
      e = '0;
      e.eop = 1'h1;
      uis_host_model_i.ev(e, '0);
      e = '0;
      e.bit_tick = 1'h1;
      repeat (16) uis_host_model_i.ev(e, '0);
      rd(REG_ERROR_FLAGS, 8'h00);
      uis_host_model_i.ev(e, '0);
      rd(REG_ERROR_FLAGS, 8'h10);
      rd(REG_EVENT_FLAGS, ((erren & 8'h10) != 8'h00) ? 8'h02 : 8'h00);
      step(3);
      stop_test();
   end

endmodule : usb_interrupt_status_logic_test
